// ---- src/slwsp_port.sv ----
// synchronous late-write sram port with wishbone status
// assumes all pins synchronous to clk_i except oe and sleep
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "slwsp_defs.svh"

// Contract
// - address, data and control are sampled only at rising edge
// - read may follow write and write follow read, no idle cycle
// - write data taken two edges after address pipelined, one flow
// - pipelined read data registered, driven at next rising edge
// - pipelined burst reads 3-1-1-1, flow-through 2-1-1-1
// - output enable acts asynchronously, forcing data drivers off
// - sleep acts asynchronously, blocks new accesses and bursts, forcing data drivers off
// - burst order select picks linear or interleaved sequence
// - writes start on the edge and are timed internally
// - writes controlled per nine-bit lane with own enable
// - selected only when all three chip selects active
// - burst advance steps internal counter, ignores new address
// - mode select low is flow-through, high is pipelined
module slwsp_port
  import slwsp_pkg::*;
(
  input  wire logic                    clk_i,                   // clock
  input  wire logic                    rst_i,                   // reset
  input  wire logic [`SLWSP_AW-1:0]    addr_i,                  // address
  input  wire logic                    edge_enable_n_i,         // edge en
  input  wire logic                    write_enable_n_i,        // write
  input  wire logic [`SLWSP_LANES-1:0] byte_write_n_i,          // lanes
  input  wire logic                    chip_select_first_n_i,   // cs 1
  input  wire logic                    chip_select_second_i,    // cs 2
  input  wire logic                    chip_select_third_n_i,   // cs 3
  input  wire logic                    burst_advance_i,         // advance
  input  wire logic                    output_enable_n_i,       // async oe
  input  wire logic                    sleep_request_i,         // sleep
  input  wire logic                    burst_order_select_i,    // 0 linear
  input  wire logic                    flow_through_select_n_i, // 0 flow
  input  wire logic [`SLWSP_DW-1:0]    data_lane_i,             // dq in
  output logic      [`SLWSP_DW-1:0]    data_lane_o,             // dq out
  output logic                         data_lane_oe_n_o,        // dq oe
  input  wire logic                    wb_cyc_i,                // cycle
  input  wire logic                    wb_stb_i,                // strobe
  input  wire logic                    wb_we_i,                 // write
  input  wire logic [`SLWSP_WB_AW-1:0] wb_adr_i,                // address
  input  wire logic [3:0]              wb_sel_i,                // lanes
  input  wire logic [31:0]             wb_dat_i,                // wdata
  output logic      [31:0]             wb_dat_o,                // rdata
  output logic                         wb_ack_o                 // ack
);

  slwsp_state_t s_r;
  slwsp_state_t s_nxt;

  logic                    pipe;
  logic                    sel;
  logic                    active;
  logic                    new_cmd;
  logic                    start_rd;
  logic                    start_wr;
  logic                    cont;
  slwsp_stage_t            cur;
  logic                    mem_wr;
  logic [`SLWSP_AW-1:0]    waddr;
  logic [`SLWSP_LANES-1:0] wlane;
  logic                    rd_go;
  logic [`SLWSP_AW-1:0]    raddr;
  logic [`SLWSP_DW-1:0]    rdata;
  logic [`SLWSP_DW-1:0]    fwd_data;
  logic                    wb_req;

  // ----------------------------------------
  // burst address sequence
  // ----------------------------------------
  function automatic logic [`SLWSP_AW-1:0] burst_addr(
    input logic [`SLWSP_AW-1:0]  base,
    input logic [`SLWSP_BCW-1:0] cnt,
    input logic                  inter
  );
    logic [`SLWSP_BCW-1:0] low;
    low = inter ? (base[`SLWSP_BCW-1:0] ^ cnt)
                : `SLWSP_BCW'(base[`SLWSP_BCW-1:0] + cnt);
    return {base[`SLWSP_AW-1:`SLWSP_BCW], low};
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign pipe   = flow_through_select_n_i;
  assign sel    = !chip_select_first_n_i && chip_select_second_i &&
                  !chip_select_third_n_i;
  assign active = !sleep_request_i && s_r.ctrl_en;
  assign new_cmd  = !burst_advance_i && sel && active;
  assign start_rd = new_cmd && write_enable_n_i;
  assign start_wr = new_cmd && !write_enable_n_i;
  assign cont     = burst_advance_i && (s_r.op != SLWSP_IDLE) && active;

  always_comb begin
    cur = '0;
    if (cont) begin
      cur.vld   = 1'b1;
      cur.wr    = (s_r.op == SLWSP_WRITE);
      cur.lanes = s_r.lanes;
      cur.addr  = burst_addr(s_r.base, `SLWSP_BCW'(s_r.bcnt + 1'b1),
                             burst_order_select_i);
    end else if (new_cmd) begin
      cur.vld   = 1'b1;
      cur.wr    = !write_enable_n_i;
      cur.lanes = ~byte_write_n_i;
      cur.addr  = addr_i;
    end
  end

  // ----------------------------------------
  // late write and read datapath
  // ----------------------------------------
  always_comb begin
    if (pipe) begin
      mem_wr = s_r.s2.vld && s_r.s2.wr;
      waddr  = s_r.s2.addr;
      wlane  = s_r.s2.lanes;
      rd_go  = s_r.s1.vld && !s_r.s1.wr;
      raddr  = s_r.s1.addr;
    end else begin
      mem_wr = s_r.s1.vld && s_r.s1.wr;
      waddr  = s_r.s1.addr;
      wlane  = s_r.s1.lanes;
      rd_go  = cur.vld && !cur.wr;
      raddr  = cur.addr;
    end
    mem_wr = mem_wr && !edge_enable_n_i;
  end

  slwsp_lane_mem u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (mem_wr),
    .waddr_i (waddr),
    .wlane_i (wlane),
    .wdata_i (data_lane_i),
    .raddr_i (raddr),
    .rdata_o (rdata)
  );

  // forward late write data to a read of the same word
  genvar gl;
  generate
    for (gl = 0; gl < `SLWSP_LANES; gl++) begin : g_fwd
      assign fwd_data[gl*`SLWSP_LANE_W +: `SLWSP_LANE_W] =
        (mem_wr && wlane[gl] && waddr == raddr)
          ? data_lane_i[gl*`SLWSP_LANE_W +: `SLWSP_LANE_W]
          : rdata[gl*`SLWSP_LANE_W +: `SLWSP_LANE_W];
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !s_r.ack;

  always_comb begin
    s_nxt = s_r;
    if (!edge_enable_n_i) begin
      if (cont) begin
        s_nxt.bcnt = `SLWSP_BCW'(s_r.bcnt + 1'b1);
      end else if (new_cmd) begin
        s_nxt.op    = write_enable_n_i ? SLWSP_READ : SLWSP_WRITE;
        s_nxt.base  = addr_i;
        s_nxt.bcnt  = '0;
        s_nxt.lanes = ~byte_write_n_i;
      end else begin
        s_nxt.op = SLWSP_IDLE;
      end
      s_nxt.s1      = cur;
      s_nxt.s2      = s_r.s1;
      s_nxt.out_vld = rd_go;
      if (rd_go) begin
        s_nxt.rd_data = fwd_data;
      end
    end
    s_nxt.ack = wb_req;
    if (wb_req && wb_we_i && wb_adr_i == `SLWSP_REG_CTRL && wb_sel_i[0]) begin
      s_nxt.ctrl_en = wb_dat_i[0];
    end
    if (wb_req && wb_we_i && wb_adr_i == `SLWSP_REG_RCNT) begin
      s_nxt.rcnt = '0;
    end
    if (wb_req && wb_we_i && wb_adr_i == `SLWSP_REG_WCNT) begin
      s_nxt.wcnt = '0;
    end
    // an access in the clearing cycle still counts
    if (rd_go && !edge_enable_n_i) begin
      s_nxt.rcnt = `SLWSP_CNT_W'(s_nxt.rcnt + `SLWSP_CNT_ONE);
    end
    if (mem_wr) begin
      s_nxt.wcnt = `SLWSP_CNT_W'(s_nxt.wcnt + `SLWSP_CNT_ONE);
    end
    s_nxt.wb_dat = '0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `SLWSP_REG_CTRL: s_nxt.wb_dat = {31'h0, s_r.ctrl_en};
        `SLWSP_REG_STAT: s_nxt.wb_dat = {25'h0, s_r.op, s_r.out_vld,
                                         sleep_request_i,
                                         burst_order_select_i, pipe};
        `SLWSP_REG_RCNT: s_nxt.wb_dat = {16'h0, s_r.rcnt};
        `SLWSP_REG_WCNT: s_nxt.wb_dat = {16'h0, s_r.wcnt};
        default:         s_nxt.wb_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r         <= '0;
      s_r.op      <= SLWSP_IDLE;
      s_r.ctrl_en <= `SLWSP_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign data_lane_o      = s_r.rd_data;
  assign data_lane_oe_n_o = !(s_r.out_vld && !output_enable_n_i &&
                              !sleep_request_i);
  assign wb_dat_o         = s_r.wb_dat;
  assign wb_ack_o         = s_r.ack;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_oe_override: assert property (
    @(posedge clk_i) disable iff (rst_i)
    output_enable_n_i |-> data_lane_oe_n_o)
    else $error("driving with output enable high");

  a_sleep_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sleep_request_i && !edge_enable_n_i) |=>
      (!s_r.s1.vld && data_lane_oe_n_o) or !sleep_request_i)
    else $error("access started during sleep");

  a_desel_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!edge_enable_n_i && !burst_advance_i && !sel) |=>
      (!s_r.s1.vld && s_r.op == SLWSP_IDLE))
    else $error("access started while deselected");

  a_ft_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!pipe && start_rd && !edge_enable_n_i) |=>
      s_r.out_vld)
    else $error("flow-through read data late");

  a_pipe_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pipe && start_rd && !edge_enable_n_i) |=>
      !s_r.out_vld || $past(rd_go) ##0
      (edge_enable_n_i or (##1 s_r.out_vld)))
    else $error("pipelined read data not at second edge");

  a_ft_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!pipe && start_wr && !edge_enable_n_i) |=>
      (edge_enable_n_i || (mem_wr && waddr == $past(addr_i))))
    else $error("flow-through write data not taken");

  a_pipe_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pipe && start_wr && !edge_enable_n_i) ##1 !edge_enable_n_i |=>
      (edge_enable_n_i || (mem_wr && waddr == $past(addr_i, 2))))
    else $error("pipelined write data not taken");

  a_rw_turn: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (start_rd && !edge_enable_n_i) ##1 (start_wr && !edge_enable_n_i)
      |=> (s_r.s1.vld && s_r.s1.wr && s_r.s2.vld && !s_r.s2.wr))
    else $error("turnaround cycle lost");

  a_burst_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cont && !edge_enable_n_i) |=>
      (s_r.bcnt == $past(s_r.bcnt) + 2'h1 &&
       s_r.base == $past(s_r.base)))
    else $error("burst counter did not step");

  a_inter_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cont && burst_order_select_i && !edge_enable_n_i) |=>
      s_r.s1.addr[1:0] == (s_r.base[1:0] ^ s_r.bcnt))
    else $error("interleaved burst address wrong");

  a_edge_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    edge_enable_n_i |=>
      (s_r.s1 == $past(s_r.s1) && s_r.out_vld == $past(s_r.out_vld)))
    else $error("state moved on a disabled edge");

endmodule

// ---- shared/slwsp_defs.svh ----
// constants of the late-write sram port
// included by the package and by every design file
`ifndef SLWSP_DEFS_SVH
`define SLWSP_DEFS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SLWSP_AW      6
`define SLWSP_DEPTH   64
`define SLWSP_LANES   4
`define SLWSP_LANE_W  9
`define SLWSP_DW      36
`define SLWSP_BCW     2

// ----------------------------------------
// wishbone register map
// ----------------------------------------
`define SLWSP_WB_AW     4
`define SLWSP_REG_CTRL  4'h0
`define SLWSP_REG_STAT  4'h4
`define SLWSP_REG_RCNT  4'h8
`define SLWSP_REG_WCNT  4'hC
`define SLWSP_CTRL_RST  1'h1
`define SLWSP_CNT_W     16
`define SLWSP_CNT_ONE   16'h0001

`endif

// ---- shared/slwsp_pkg.sv ----
// types shared by the late-write sram port modules
// assumes slwsp_defs.svh on the include path
`include "slwsp_defs.svh"

package slwsp_pkg;

  // ----------------------------------------
  // operation of the running burst
  // ----------------------------------------
  typedef enum logic [2:0] {
    SLWSP_IDLE  = 3'b001,
    SLWSP_READ  = 3'b010,
    SLWSP_WRITE = 3'b100
  } slwsp_op_t;

  // ----------------------------------------
  // one access in flight
  // ----------------------------------------
  typedef struct packed {
    logic                      vld;
    logic                      wr;
    logic [`SLWSP_LANES-1:0]   lanes;
    logic [`SLWSP_AW-1:0]      addr;
  } slwsp_stage_t;

  typedef struct packed {
    slwsp_op_t                 op;
    logic [`SLWSP_AW-1:0]      base;
    logic [`SLWSP_BCW-1:0]     bcnt;
    logic [`SLWSP_LANES-1:0]   lanes;
    slwsp_stage_t              s1;
    slwsp_stage_t              s2;
    logic [`SLWSP_DW-1:0]      rd_data;
    logic                      out_vld;
    logic                      ctrl_en;
    logic                      ack;
    logic [31:0]               wb_dat;
    logic [`SLWSP_CNT_W-1:0]   rcnt;
    logic [`SLWSP_CNT_W-1:0]   wcnt;
  } slwsp_state_t;

  typedef struct packed {
    logic [`SLWSP_DEPTH-1:0][`SLWSP_DW-1:0] mem;
  } slwsp_mem_t;

endpackage

// ---- src/slwsp_lane_mem.sv ----
// byte-lane writable word array held in flip-flops
// assumes writes are already timed by the port logic
`timescale 1ns/1ps
`include "slwsp_defs.svh"

module slwsp_lane_mem
  import slwsp_pkg::*;
(
  input  wire logic                    clk_i,   // clock
  input  wire logic                    rst_i,   // sync reset
  input  wire logic                    wr_i,    // write this edge
  input  wire logic [`SLWSP_AW-1:0]    waddr_i, // write address
  input  wire logic [`SLWSP_LANES-1:0] wlane_i, // lane enables
  input  wire logic [`SLWSP_DW-1:0]    wdata_i, // write data
  input  wire logic [`SLWSP_AW-1:0]    raddr_i, // read address
  output logic      [`SLWSP_DW-1:0]    rdata_o  // read word
);

  slwsp_mem_t st_r;
  slwsp_mem_t st_nxt;

  // ----------------------------------------
  // per-lane write
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    for (int l = 0; l < `SLWSP_LANES; l++) begin
      if (wr_i && wlane_i[l]) begin
        st_nxt.mem[waddr_i][l*`SLWSP_LANE_W +: `SLWSP_LANE_W] =
          wdata_i[l*`SLWSP_LANE_W +: `SLWSP_LANE_W];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.mem[raddr_i];

  a_lane_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && !wlane_i[0]) |=>
      st_r.mem[$past(waddr_i)][`SLWSP_LANE_W-1:0] ==
      $past(st_r.mem[waddr_i][`SLWSP_LANE_W-1:0]))
    else $error("disabled lane 0 changed");

endmodule

// ---- tb/slwsp_ctrl_model.sv ----
// far-side controller model: late write data for the sram port
// assumes write beats are flagged by the bench in the issuing cycle
`timescale 1ns/1ps
`include "slwsp_defs.svh"

module slwsp_ctrl_model
  import slwsp_pkg::*;
(
  input  wire logic                 clk_i,  // clock
  input  wire logic                 cke_n_i, // 1 edge ignored
  input  wire logic                 pipe_i, // 1 pipelined
  input  wire logic                 wr_i,   // write beat issued
  input  wire logic [`SLWSP_DW-1:0] wd_i,   // its data
  output logic      [`SLWSP_DW-1:0] dq_o    // data toward the port
);
  logic                 v1 = 1'b0;
  logic                 v2 = 1'b0;
  logic [`SLWSP_DW-1:0] d1, d2, last;

  // data one edge late flow-through, two late pipelined
  // a frozen edge moves nothing, as in the port
  always @(posedge clk_i) begin
    if (!cke_n_i) begin
      v1 <= wr_i;
      d1 <= wd_i;
      v2 <= v1;
      d2 <= d1;
      if (pipe_i ? v2 : v1)
        last <= pipe_i ? d2 : d1;
    end
  end

  // released bus shows the inverse of the last word
  always_comb begin
    if (pipe_i ? v2 : v1)
      dq_o = pipe_i ? d2 : d1;
    else
      dq_o = ~last;
  end
endmodule

// ---- tb/sync_late_write_sram_port_tb_top.sv ----
// self-checking bench of the late-write sram port
// assumes the port and the controller model compiled before
`timescale 1ns/1ps
`include "slwsp_defs.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module sync_late_write_sram_port_tb_top
  import slwsp_pkg::*;
;
  logic clk_i = 0, rst_i = 1, we_n = 1, cs1_n = 1, cs2 = 1, cs3_n = 0;
  logic burst_advance = 0, oen = 0, slp = 0, bord = 0, ft_n = 0, wr_cmd = 0;
  logic cke_n = 0, zz = 0, frz = 0;
  logic [35:0] msk = 0;
  logic cyc = 0, stb = 0, wwe = 0, pipe = 0, en = 1, mon_on = 0;
  logic [5:0] addr = 0, base = 0;
  logic [3:0] bw_n = 0, wadr = 0;
  logic [1:0] k = 0;
  logic [31:0] wdat = 0, rd;
  logic [35:0] wd = 0, dq_in, dq_out, refm [64], ed [8];
  logic [7:0] ev = 0;
  logic [2:0] cnt = 0;
  logic [31:0] wb_dat_o;
  logic oe_n_o, wb_ack_o;
  int checked = 0, mismatches = 0, bop = 0, rcnt = 0, wcnt = 0;
  int seed = 32'h9085;

  slwsp_port uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
    .edge_enable_n_i(cke_n), .write_enable_n_i(we_n), .byte_write_n_i(bw_n),
    .chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2),
    .chip_select_third_n_i(cs3_n), .burst_advance_i(burst_advance),
    .output_enable_n_i(oen), .sleep_request_i(slp),
    .burst_order_select_i(bord), .flow_through_select_n_i(ft_n),
    .data_lane_i(dq_in), .data_lane_o(dq_out), .data_lane_oe_n_o(oe_n_o),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(wadr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  slwsp_ctrl_model partner (.clk_i(clk_i), .cke_n_i(cke_n),
    .pipe_i(pipe), .wr_i(wr_cmd),
    .wd_i(wd), .dq_o(dq_in));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // read results due at this edge, drivers off otherwise
  // a frozen edge keeps the slot, the result still stands
  always @(posedge clk_i) begin
    if (mon_on) begin
      `CHK("oe_n", ~(ev[cnt] & ~oen & ~slp), oe_n_o)
      if (ev[cnt])
        `CHK("rdata", ed[cnt], dq_out)
      if (!cke_n)
        ev[cnt] = 1'b0;
    end
    if (!cke_n)
      cnt <= cnt + 3'h1;
  end

  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one sram cycle: 0 deselect, 1 read, 2 write, 3 advance
  task automatic step(input int kind, input logic [5:0] a,
                      input logic [3:0] bn, input logic [35:0] d);
    logic [5:0]  ea;
    @(posedge clk_i);
    if (!en || zz)
      bop = 0;
    else if (kind == 1 || kind == 2) begin
      bop = kind;
      base = a;
      k = 2'h0;
      for (int l = 0; l < 4; l++)
        msk[9*l +: 9] = {9{~bn[l]}};
    end else if (kind == 3 && bop != 0)
      k = k + 2'h1;
    else
      bop = 0;
    ea = bord ? (base ^ {4'h0, k}) : {base[5:2], base[1:0] + k};
    burst_advance <= (kind == 3);
    cs1_n <= (kind == 0 && a[1:0] == 2'h0);
    cs2 <= !(kind == 0 && a[1:0] == 2'h1);
    cs3_n <= (kind == 0 && a[1:0] >= 2'h2);
    we_n <= (kind != 2);
    addr <= a;
    bw_n <= bn;
    wd <= d;
    wr_cmd <= (bop == 2);
    slp <= zz;
    if (bop == 2) begin
      refm[ea] = (refm[ea] & ~msk) | (d & msk);
      wcnt++;
    end
    if (bop == 1) begin
      ev[cnt + (pipe ? 3'h3 : 3'h2)] = 1'b1;
      ed[cnt + (pipe ? 3'h3 : 3'h2)] = refm[ea];
      rcnt++;
    end
    // one ignored edge before the command is taken
    if (frz) begin
      cke_n <= 1'b1;
      @(posedge clk_i);
      cke_n <= 1'b0;
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] ad,
                    input logic [31:0] dt);
    int n;
    step(0, 6'h0, 4'h0, 36'h0);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    wadr <= ad;
    wdat <= dt;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      complete_run;
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic do_reset(input logic [1:0] md);
    mon_on = 0;
    rst_i <= 1'b1;
    ft_n <= md[0];
    pipe = md[0];
    bord <= md[1];
    en = 1;
    bop = 0;
    foreach (refm[i])
      refm[i] = '0;
    ev = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    mon_on = 1;
  endtask

  initial begin
    logic [31:0] r;
    for (int md = 0; md < 4; md++) begin
      do_reset(md[1:0]);
      wb(0, 4'h0, 0);
      `CHK("ctrl", 32'h1, rd)
      wb(0, 4'h4, 0);
      `CHK("status", {3'b001, 2'b00, md[1:0]}, rd[6:0])
      wb(0, 4'h2, 0);
      `CHK("unmapped", 32'h0, rd)
      wb(1, 4'h0, 0);
      en = 0;
      step(2, 6'h01, 4'h0, 36'hA_5A5A_5A5A);
      en = 1;
      wb(1, 4'h0, 1);
      wb(1, 4'h8, 0);
      wb(1, 4'hC, 0);
      rcnt = 0;
      wcnt = 0;
      step(2, 6'h03, 4'h0, 36'hF_0123_4567);
      step(1, 6'h03, 4'h0, 0);
      step(2, 6'h03, 4'hD, 36'h0_0000_0000);
      step(1, 6'h03, 4'h0, 0);
      step(1, 6'h01, 4'h0, 0);
      for (int j = 0; j < 3; j++)
        step(2, 6'h07, 4'h0, 36'h7_7777_7777);
      for (int j = 0; j < 4; j++)
        step(j ? 3 : 2, 6'h05, 4'h0, {4'h1, 32'h0} * (j + 1));
      for (int j = 0; j < 5; j++)
        step(j ? 3 : 1, 6'h06, 4'h0, 0);
      // oe off across a result, sleep refuses a write, a frozen edge
      step(1, 6'h03, 4'h0, 0);
      oen <= 1'b1;
      zz = 1;
      step(2, 6'h02, 4'h0, 36'h5_5555_5555);
      zz = 0;
      frz = 1;
      step(1, 6'h03, 4'h0, 0);
      frz = 0;
      oen <= 1'b0;
      step(3, 6'h03, 4'h0, 0);
      repeat (60) begin
        r = $random(seed);
        step(r[1:0], {3'h0, r[4:2]}, r[11:8], {r[15:12], $random(seed)});
      end
      wb(0, 4'h8, 0);
      `CHK("rcount", rcnt[15:0], rd[15:0])
      wb(0, 4'hC, 0);
      `CHK("wcount", wcnt[15:0], rd[15:0])
    end
    step(1, 6'h03, 4'h0, 0);
    step(0, 6'h0, 4'h0, 0);
    step(0, 6'h0, 4'h0, 0);
    for (int i = 0; i < 2; i++) begin
      #20;
      if (i == 0)
        oen = 1'b1;
      else
        slp = 1'b1;
      #1 `CHK("oe_async", 1'b1, oe_n_o)
      oen = 1'b0;
      slp = 1'b0;
      #1 `CHK("oe_back", 1'b0, oe_n_o)
    end
    step(0, 6'h0, 4'h0, 0);
    repeat (4) @(posedge clk_i);
    complete_run;
  end
endmodule
